// ### design/cbsj_decoder.sv
// Decode and execute of the conditional bit subroutine jump.
// Assumes the core presents fetched words and operands with valid strobes
// on sys_clk; an external stack and register file act on the pulses.
// Summary of operation
// - Test one operand bit, index 0-31
// - Taken: push return address and status word
// - Taken: load PC from 32-bit extension
// - Not taken: PC+2, no push
// - Effective address source: post-update effective address register on both outcomes
// - Upper slot source decrements stack pointer
// - Push overwrites level upper slot came from
// - Condition, exception bits left unchanged
// - Register, short and I/O short sources
// - I/O short: 1010, leading one, S space
// - Absolute short: 1010, leading zero, 7 bits
// - Effective address: 1000, no displacement mode
// - Bit index in low five bits
// - Two words, six cycles plus jump wait
// - Short jump target sign extended
`timescale 1ns/1ps
module cbsj_decoder
    import cbsj_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire logic [cbsj_pkg::WORD_W-1:0] instr_word,
    input wire logic ext_valid,
    input wire logic [cbsj_pkg::WORD_W-1:0] ext_word,
    input wire logic opnd_valid,
    input wire logic [cbsj_pkg::WORD_W-1:0] opnd_data,
    input wire logic [cbsj_pkg::WORD_W-1:0] pc_in,
    input wire logic [cbsj_pkg::WORD_W-1:0] status_word,
    input wire logic [cbsj_pkg::SP_W-1:0] sp_in,
    input wire logic jump_ready,
    input wire logic [cbsj_pkg::SHORT_TGT_W-1:0] short_tgt,
    output logic [cbsj_pkg::WORD_W-1:0] short_tgt_ext,
    output logic instr_match,
    output logic illegal,
    output logic busy,
    output logic opnd_req,
    output logic opnd_is_mem,
    output logic opnd_space_y,
    output logic opnd_is_io,
    output logic [cbsj_pkg::SHORT_ADDR_W-1:0] opnd_addr,
    output logic [cbsj_pkg::REG_SEL_W-1:0] opnd_reg_sel,
    output logic [cbsj_pkg::EA_FIELD_W-1:0] ea_field,
    output logic ea_update,
    output logic pc_load,
    output logic [cbsj_pkg::WORD_W-1:0] pc_out,
    output logic push,
    output logic [cbsj_pkg::WORD_W-1:0] push_upper,
    output logic [cbsj_pkg::WORD_W-1:0] push_lower,
    output logic sp_load,
    output logic [cbsj_pkg::SP_W-1:0] sp_out,
    output logic taken,
    output logic done,
    output logic cc_write
);
    import cbsj_pkg::*;

    cbsj_state_e state_q, state_d;
    logic [WORD_W-1:0] ir_q;
    logic [WORD_W-1:0] ext_q;
    logic [WORD_W-1:0] ret_q;
    logic [SP_W-1:0] sp_q;
    logic [CNT_W-1:0] cnt_q;
    logic bit_q;

    // Format decode
    wire hi_ok = ir_word_hi(instr_word);
    wire [3:0] opc = instr_word[OPC_LSB +: 4];
    wire tail_ok = instr_word[TAIL_LSB +: 3] == LOW_TAIL_PAT;
    wire mem_low = instr_word[LOW_MEM_LSB +: 3] == LOW_MEM_PAT;
    wire fmt_short = hi_ok && opc == OPC_SHORT && mem_low && tail_ok;
    wire fmt_io = fmt_short && instr_word[LEAD_BIT];
    wire fmt_abs = fmt_short && !instr_word[LEAD_BIT];
    wire ea_pad_ok = instr_word[EA_PAD_LSB +: 2] == EA_PAD;
    wire [2:0] ea_mode = instr_word[EA_LSB + 3 +: 3];
    wire fmt_ea_raw = hi_ok && opc == OPC_EA && mem_low && tail_ok && ea_pad_ok;
    wire fmt_ea = fmt_ea_raw && ea_mode != EA_MODE_DISP;
    wire fmt_reg = hi_ok && opc == OPC_REG && !instr_word[REG_PAD_BIT]
        && instr_word[LOW_REG_LSB +: 4] == LOW_REG_PAT
        && tail_ok;
    wire start = state_q == CBSJ_IDLE && instr_valid && instr_match;

    function automatic logic ir_word_hi(input logic [WORD_W-1:0] w);
        ir_word_hi = w[WORD_W-1:OPC_HI_LSB] == OPC_HI;
    endfunction

    assign instr_match = fmt_io || fmt_abs || fmt_ea || fmt_reg;
    assign illegal = instr_valid && state_q == CBSJ_IDLE && fmt_ea_raw
        && !fmt_ea;

    // Operand addressing from the held instruction
    wire ir_reg = ir_q[OPC_LSB +: 4] == OPC_REG;
    wire ir_ea = ir_q[OPC_LSB +: 4] == OPC_EA;
    wire [REG_SEL_W-1:0] ir_sel = ir_q[REG_LSB +: REG_SEL_W];
    wire src_upper = ir_reg && ir_sel == SEL_UPPER;
    wire [BIT_IDX_W-1:0] bit_idx = ir_q[BIT_IDX_W-1:0];
    wire test_bit = opnd_data[bit_idx];

    assign busy = state_q != CBSJ_IDLE;
    assign opnd_req = state_q == CBSJ_OPND;
    assign opnd_is_mem = !ir_reg;
    assign opnd_space_y = !ir_reg && ir_q[SPACE_BIT];
    assign opnd_is_io = !ir_reg && !ir_ea && ir_q[LEAD_BIT];
    assign opnd_addr = ir_q[FIELD_LSB +: SHORT_ADDR_W];
    assign opnd_reg_sel = ir_sel;
    assign ea_field = ir_q[EA_LSB +: EA_FIELD_W];
    assign cc_write = 1'b0;
    // Short form target for the plain subroutine jump
    assign short_tgt_ext = {{(WORD_W-SHORT_TGT_W){short_tgt[SHORT_TGT_W-1]}},
        short_tgt};

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            CBSJ_IDLE: if (start) state_d = CBSJ_EXT;
            CBSJ_EXT: if (ext_valid) state_d = CBSJ_OPND;
            CBSJ_OPND: if (opnd_valid) state_d = CBSJ_EXEC;
            CBSJ_EXEC: if (cnt_q >= CNT_LAST && (!bit_q || jump_ready))
                state_d = CBSJ_DONE;
            CBSJ_DONE: state_d = CBSJ_IDLE;
            default: state_d = CBSJ_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= CBSJ_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // Cycle counter from instruction acceptance
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (start) cnt_q <= '0;
            else if (busy && cnt_q != '1) cnt_q <= cnt_q + 1'b1;
        end
    end

    // Instruction, extension and return address capture
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ir_q <= '0;
            ext_q <= '0;
            ret_q <= '0;
        end else if (clk_en) begin
            if (start) ir_q <= instr_word;
            if (start) ret_q <= pc_in + PC_ONE + PC_ONE;
            if (state_q == CBSJ_EXT && ext_valid) ext_q <= ext_word;
        end
    end

    // Bit test and stack pointer tracking
    wire [SP_W-1:0] sp_rd = src_upper ? sp_in - SP_ONE : sp_in;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_q <= 1'b0;
            sp_q <= '0;
        end else if (clk_en && state_q == CBSJ_OPND && opnd_valid) begin
            bit_q <= test_bit;
            sp_q <= sp_rd;
        end
    end

    // Completion outputs, registered
    wire fin = state_q == CBSJ_EXEC && state_d == CBSJ_DONE;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_load <= 1'b0;
            pc_out <= '0;
            push <= 1'b0;
            push_upper <= '0;
            push_lower <= '0;
            sp_load <= 1'b0;
            sp_out <= '0;
            taken <= 1'b0;
            done <= 1'b0;
            ea_update <= 1'b0;
        end else if (clk_en) begin
            pc_load <= fin;
            done <= fin;
            taken <= fin && bit_q;
            push <= fin && bit_q;
            ea_update <= fin && ir_ea;
            sp_load <= fin && (bit_q || src_upper);
            if (fin) begin
                pc_out <= bit_q ? ext_q : ret_q;
                push_upper <= ret_q;
                push_lower <= status_word;
                sp_out <= bit_q ? sp_q + SP_ONE : sp_q;
            end
        end
    end

    // Checks
    sequence fin_s;
        state_q == CBSJ_EXEC && state_d == CBSJ_DONE;
    endsequence
    push_on_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en ##0 fin_s |=> push == bit_q)
        else $error("push not tied to tested bit");
    target_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        push |-> pc_load && pc_out == ext_q)
        else $error("taken jump target wrong");
    no_push_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pc_load && !taken |-> !push && pc_out == ret_q)
        else $error("not taken path pushed or wrong pc");
    ea_always_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        done && ir_ea |-> ea_update)
        else $error("ea update missing");
    same_level_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        push && src_upper |-> sp_out == $past(sp_in))
        else $error("push level differs from read level");
    cc_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !cc_write)
        else $error("condition bits written");
    min_time_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && start |=> !done [*5])
        else $error("finished under six cycles");
    no_disp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        fmt_ea_raw && ea_mode == EA_MODE_DISP |-> !instr_match)
        else $error("displacement mode accepted");
    push_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        push && !src_upper |-> sp_out == $past(sp_q) + SP_ONE)
        else $error("stack pointer not incremented");

    // Steps of one instruction, from acceptance to the operand
    sequence accept_s;
        clk_en && start;
    endsequence
    sequence ext_take_s;
        clk_en && state_q == CBSJ_EXT && ext_valid;
    endsequence
    sequence opnd_take_s;
        clk_en && state_q == CBSJ_OPND && opnd_valid;
    endsequence

    // Sequencing through the fetch states
    accept_ext_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        accept_s |=> state_q == CBSJ_EXT)
        else $error("accepted word did not start fetch");
    ext_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ext_take_s |=> ext_q == $past(ext_word))
        else $error("extension word not held");
    bit_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        opnd_take_s |=> bit_q == $past(test_bit))
        else $error("tested bit not captured");
    ret_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        accept_s |=> ret_q - $past(pc_in) == 32'h0000_0002)
        else $error("return address not past both words");

    // Stack pointer on an upper slot read and on a not-taken jump
    upper_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && state_q == CBSJ_OPND && opnd_valid && src_upper
        |=> sp_q == $past(sp_in) - SP_ONE)
        else $error("upper slot read did not decrement");
    not_taken_sp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pc_load && !taken && !src_upper |-> !sp_load)
        else $error("stack pointer moved on not taken");

    // Completion pulses and the jump wait
    exec_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && state_q == CBSJ_EXEC && bit_q && !jump_ready
        |=> state_q == CBSJ_EXEC)
        else $error("finished before jump access");
    done_once_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        done ##1 clk_en |=> !done)
        else $error("done longer than one cycle");
    taken_pulses_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        taken |-> done && pc_load && push)
        else $error("taken without push and load");
    taken_target_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        taken |-> pc_out == ext_q)
        else $error("taken target not the extension");
    push_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        push |-> push_lower == $past(status_word))
        else $error("lower slot not the status word");
    ea_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ea_update |-> done)
        else $error("address update outside completion");
    ir_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        busy |=> $stable(ir_q))
        else $error("instruction changed while busy");

    // Decode and source selection
    illegal_ref_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        illegal |-> !instr_match)
        else $error("illegal word matched");
    reg_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        opnd_req && !opnd_is_mem |-> !opnd_is_io && !opnd_space_y)
        else $error("register source flagged as memory");
    short_sext_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        short_tgt_ext[SHORT_TGT_W-1:0] == short_tgt
        && short_tgt_ext[WORD_W-1] == short_tgt[SHORT_TGT_W-1])
        else $error("short target not sign extended");
endmodule

// ### include/cbsj_pkg.sv
// Package for the conditional bit subroutine jump decoder.
// Assumes a 32-bit core with a 7-bit register select and a 5-bit bit index.
package cbsj_pkg;
    localparam int WORD_W = 32;
    localparam int REG_SEL_W = 7;
    localparam int BIT_IDX_W = 5;
    localparam int SHORT_ADDR_W = 7;
    localparam int EA_FIELD_W = 6;
    localparam int SP_W = 6;
    // Opcode fields
    localparam logic [7:0] OPC_HI = 8'h02;
    localparam logic [3:0] OPC_EA = 4'h8;
    localparam logic [3:0] OPC_SHORT = 4'hA;
    localparam logic [3:0] OPC_REG = 4'hB;
    localparam logic [2:0] LOW_MEM_PAT = 3'h6;
    localparam logic [3:0] LOW_REG_PAT = 4'hC;
    localparam logic [2:0] LOW_TAIL_PAT = 3'h4;
    localparam logic [1:0] EA_PAD = 2'h0;
    // Field positions
    localparam int OPC_HI_LSB = 24;
    localparam int OPC_LSB = 20;
    localparam int LEAD_BIT = 19;
    localparam int FIELD_LSB = 12;
    localparam int SPACE_BIT = 8;
    localparam int LOW_MEM_LSB = 9;
    localparam int LOW_REG_LSB = 8;
    localparam int TAIL_LSB = 5;
    localparam int EA_LSB = 14;
    localparam int EA_PAD_LSB = 12;
    localparam int REG_LSB = 13;
    localparam int REG_PAD_BIT = 12;
    // Effective address modes (MMM); displacement-indexed is excluded
    localparam logic [2:0] EA_MODE_DISP = 3'h7;
    // Register-direct select codes
    localparam logic [6:0] SEL_STATUS = 7'h79;
    localparam logic [6:0] SEL_UPPER = 7'h7C;
    // Timing
    localparam int BASE_CYCLES = 6;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BASE_CYCLES - 1);
    localparam logic [SP_W-1:0] SP_ONE = 6'h01;
    localparam logic [WORD_W-1:0] PC_ONE = 32'h0000_0001;
    // Short jump target
    localparam int SHORT_TGT_W = 15;
    typedef enum logic [4:0] {
        CBSJ_IDLE = 5'b00001,
        CBSJ_EXT = 5'b00010,
        CBSJ_OPND = 5'b00100,
        CBSJ_EXEC = 5'b01000,
        CBSJ_DONE = 5'b10000
    } cbsj_state_e;
endpackage

// ### verification/bit_test_subroutine_jump_tb_top.sv
// Testbench for the bit test subroutine jump decoder.
// Assumes the core model answers fetches; clock enable held high.
`timescale 1ns/1ps
module bit_test_subroutine_jump_tb_top;
    import cbsj_pkg::*;
    typedef logic [WORD_W-1:0] cbsj_word_t;
    logic sys_clk, rst_b, instr_valid, ext_valid, opnd_valid, jump_ready;
    logic clk_en, slow, instr_match, illegal, busy, opnd_req, opnd_is_mem;
    logic opnd_space_y, opnd_is_io, ea_update, pc_load, push, sp_load;
    logic taken, done, cc_write;
    cbsj_word_t instr_word, ext_word, opnd_data, pc_in, status_word;
    cbsj_word_t ext_val, opnd_val, short_tgt_ext, pc_out, push_upper;
    cbsj_word_t push_lower;
    logic [SP_W-1:0] sp_in, sp_out;
    logic [SHORT_TGT_W-1:0] short_tgt;
    logic [6:0] opnd_addr, opnd_reg_sel;
    logic [5:0] ea_field;
    int mismatches, cmp_count, n, np, ne, ns, nt, nl, nc;

    cbsj_decoder u_dut (.*);
    cbsj_core_model u_core (.*);

    // Core clock
    initial begin
        sys_clk = 0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk(string what, cbsj_word_t seen, cbsj_word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic cbsj_word_t enc(logic [3:0] opc, logic ld,
            logic [6:0] fld, logic s, logic [4:0] b);
        cbsj_word_t w;
        w = '0;
        w[OPC_HI_LSB +: 8] = OPC_HI;
        w[OPC_LSB +: 4] = opc;
        w[LEAD_BIT] = ld;
        w[FIELD_LSB +: 7] = fld;
        w[LOW_MEM_LSB +: 3] = LOW_MEM_PAT;
        w[SPACE_BIT] = s;
        w[TAIL_LSB +: 3] = LOW_TAIL_PAT;
        w[4:0] = b;
        return w;
    endfunction

    function automatic cbsj_word_t eaw(logic [5:0] ea, logic s,
            logic [4:0] b);
        cbsj_word_t w;
        w = enc(OPC_EA, 1'b0, 7'h00, s, b);
        w[EA_LSB +: EA_FIELD_W] = ea;
        return w;
    endfunction

    function automatic cbsj_word_t regw(logic [6:0] sel, logic [2:0] b);
        cbsj_word_t w;
        w = enc(OPC_REG, 1'b0, 7'h00, 1'b0, {2'h0, b});
        w[REG_LSB +: REG_SEL_W] = sel;
        w[REG_PAD_BIT] = 1'b0;
        w[LOW_REG_LSB +: 4] = LOW_REG_PAT;
        return w;
    endfunction

    // Issue one instruction and tally pulses up to done
    task automatic run(cbsj_word_t w, cbsj_word_t op, logic tk);
        @(posedge sys_clk);
        #1;
        instr_word = w;
        opnd_val = op;
        ext_val = {w[15:0], 16'hC0DE};
        instr_valid = 1;
        #1;
        chk("match", instr_match, 1);
        @(posedge sys_clk);
        #1;
        instr_valid = 0;
        {n, np, ne, ns, nt, nl, nc} = '0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
            np += push;
            ne += ea_update;
            ns += sp_load;
            nt += taken;
            nl += pc_load;
            nc += cc_write;
        end while (done !== 1'b1 && n < 100);
        chk("cycles", n >= BASE_CYCLES, 1);
        chk("taken", nt, tk);
        chk("push", np, tk);
        chk("pc load", nl, 1);
        chk("pc", pc_out, tk ? ext_val : pc_in + 32'h2);
        chk("cc write", nc, 0);
        if (tk) begin
            chk("upper", push_upper, pc_in + 32'h2);
            chk("lower", push_lower, status_word);
        end
    endtask

    // Absolute short in X, top bit set
    task automatic t_short(logic s);
        slow = s;
        sp_in = 6'h05;
        run(enc(OPC_SHORT, 1'b0, 7'h55, 1'b0, 5'h1F), 32'h8000_0000, 1);
        chk("mem", opnd_is_mem, 1);
        chk("io", opnd_is_io, 0);
        chk("addr", opnd_addr, 32'h55);
        chk("sp", sp_out, 32'h06);
        chk("sp load", ns, 1);
        if (s) chk("slow", n > BASE_CYCLES, 1);
        else chk("fast", n, BASE_CYCLES);
        slow = 0;
        $display("short test done");
    endtask

    // I/O short in Y, bit 0 clear among set bits
    task automatic t_io();
        run(enc(OPC_SHORT, 1'b1, 7'h2A, 1'b1, 5'h00), 32'hFFFF_FFFE, 0);
        chk("io", opnd_is_io, 1);
        chk("space", opnd_space_y, 1);
        chk("addr", opnd_addr, 32'h2A);
        chk("sp load", ns, 0);
        $display("io test done");
    endtask

    // Effective address, both outcomes, then the barred mode
    task automatic t_ea();
        for (int k = 0; k < 2; k++) begin
            run(eaw(6'h1B, 1'b0, 5'h10), 32'(k) << 16, k[0]);
            chk("ea field", ea_field, 32'h1B);
            chk("ea update", ne, 1);
        end
        @(posedge sys_clk);
        #1;
        instr_word = eaw({EA_MODE_DISP, 3'h2}, 1'b0, 5'h10);
        instr_valid = 1;
        #1;
        chk("illegal", illegal, 1);
        chk("refused", instr_match, 0);
        @(posedge sys_clk);
        #1;
        instr_valid = 0;
        chk("idle", busy, 0);
        $display("ea test done");
    endtask

    // Register sources: status word, then upper stack slot
    task automatic t_reg();
        status_word = 32'h0000_0008;
        run(regw(SEL_STATUS, 3'h3), status_word, 1);
        chk("sel", opnd_reg_sel, SEL_STATUS);
        chk("mem", opnd_is_mem, 0);
        for (int k = 0; k < 2; k++) begin
            sp_in = 6'h09;
            run(regw(SEL_UPPER, 3'h2), 32'(k) << 2, k[0]);
            chk("sp", sp_out, k ? 32'h09 : 32'h08);
            chk("sp load", ns != 0, 1);
        end
        $display("reg test done");
    endtask

    // Sign extension of the short jump target
    task automatic t_sign();
        short_tgt = 15'h4000;
        #1;
        chk("sext neg", short_tgt_ext, 32'hFFFF_C000);
        @(posedge sys_clk);
        #1;
        short_tgt = 15'h3FFF;
        #1;
        chk("sext pos", short_tgt_ext, 32'h0000_3FFF);
        $display("sign test done");
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Reset, then the scenarios back to back
    initial begin
        {rst_b, instr_valid, slow, short_tgt, sp_in} = '0;
        {instr_word, opnd_val, ext_val} = '0;
        clk_en = 1;
        pc_in = 32'h0000_1000;
        status_word = 32'h00A5_0000;
        {mismatches, cmp_count} = '0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1;
        t_short(1'b0);
        t_short(1'b1);
        t_io();
        t_ea();
        t_reg();
        t_sign();
        wrap_up();
    end

    // Watchdog against a hung handshake
    initial begin
        #20000;
        mismatches++;
        wrap_up();
    end
endmodule

// ### verification/cbsj_core_model.sv
// Core model: supplies extension word, operand and jump wait.
// Assumes busy and opnd_req from the decoder; slow adds wait cycles.
`timescale 1ns/1ps
module cbsj_core_model
    import cbsj_pkg::*;
(
    input wire logic sys_clk,
    input wire logic busy,
    input wire logic opnd_req,
    input wire logic slow,
    input wire logic [cbsj_pkg::WORD_W-1:0] ext_val,
    input wire logic [cbsj_pkg::WORD_W-1:0] opnd_val,
    output logic ext_valid,
    output logic [cbsj_pkg::WORD_W-1:0] ext_word,
    output logic opnd_valid,
    output logic [cbsj_pkg::WORD_W-1:0] opnd_data,
    output logic jump_ready
);
    int age;
    logic got;
    // Hold each word until taken; idle lines carry the inverse
    initial begin
        {ext_valid, opnd_valid, jump_ready, got} = '0;
        {ext_word, opnd_data} = '0;
        age = 0;
        forever begin
            @(posedge sys_clk);
            #1;
            age = busy ? age + 1 : 0;
            got = busy && (got || opnd_req);
            ext_valid = busy && !got && age > (slow ? 3 : 0);
            opnd_valid = opnd_req && age > (slow ? 6 : 0);
            jump_ready = !slow || age > 10;
            ext_word = ext_valid ? ext_val : ~ext_val;
            opnd_data = opnd_valid ? opnd_val : ~opnd_val;
        end
    end
endmodule
